// [fpwm_acoustic.sv]
`timescale 1ns/1ps

// What this block does
// - smoothing ramps output one gradually to target
// - ramp codes step 1,2,3,4,8,12,24,48
// - codes give 35 s down to 0.8 s
// - ctrl one bit 3 enables output one smoothing
// - sync set: sense two three four follow three
// - sync clear: only sense three four follow
// - bit 5 picks off or floor, output one
// - bit 6 picks off or floor, output two
// - bit 7 picks off or floor, output three
// - lock makes both acoustic registers read-only
// - ctrl two bits 2:0 rate output three
// - ctrl two bit 3 enables output three
// - ctrl two bits 6:4 rate output two
// - ctrl two bit 7 enables output two
// - minimum duty registers reset to 0x80
// - minimum duty writes ignored in automatic mode
// - minimum duty scales linearly, 0xff full speed
// - slow bit makes every ramp four times longer
// - between threshold and hysteresis hold floor duty
module fpwm_acoustic #(
  parameter int SLOT_LEN = fpwm_pkg::SLOT_CYCLES
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // register access
  input  wire fpwm_pkg::fpwm_reg_req_t reg_req,
  output logic                  [7:0]  reg_rdata,
  // configuration from neighbouring registers
  input  wire logic                    cfg_lock,
  input  wire logic                    slow_ramp,
  // fan control loop, one entry per output
  input  wire fpwm_pkg::fpwm_chan_in_t chan_in [3],
  // smoothed duty per output
  output logic                  [7:0]  fan_drive_one,
  output logic                  [7:0]  fan_drive_two,
  output logic                  [7:0]  fan_drive_three,
  // tachometer synchronisation to output three
  output logic                         speed_sense_two_sync,
  output logic                         speed_sense_three_sync,
  output logic                         speed_sense_four_sync
);
  import fpwm_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] acoustic_ctrl_one;
  logic [7:0] acoustic_ctrl_two;
  logic [7:0] min_duty [3];

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire hit_one  = (reg_req.addr == ADDR_ACOUSTIC_CTRL_ONE);
  wire hit_two  = (reg_req.addr == ADDR_ACOUSTIC_CTRL_TWO);
  wire [2:0] hit_min;
  assign hit_min[0] = (reg_req.addr == ADDR_FAN_ONE_MIN_DUTY);
  assign hit_min[1] = (reg_req.addr == ADDR_FAN_TWO_MIN_DUTY);
  assign hit_min[2] = (reg_req.addr == ADDR_FAN_THREE_MIN_DUTY);

  // lock gates acoustic writes; auto mode gates each floor write
  wire wr_one = reg_req.wr && hit_one && !cfg_lock;
  wire wr_two = reg_req.wr && hit_two && !cfg_lock;

  // acoustic control registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acoustic_ctrl_one <= RST_ACOUSTIC_CTRL;
      acoustic_ctrl_two <= RST_ACOUSTIC_CTRL;
    end else begin
      if (wr_one) begin
        acoustic_ctrl_one <= reg_req.wdata;
      end
      if (wr_two) begin
        acoustic_ctrl_two <= reg_req.wdata;
      end
    end
  end

  // ****************************************************************
  // field extraction
  // ****************************************************************
  wire [2:0] ramp_rate_out_one   =
    acoustic_ctrl_one[RATE_ONE_LSB +: 3];
  wire [2:0] ramp_rate_out_two   =
    acoustic_ctrl_two[RATE_TWO_LSB +: 3];
  wire [2:0] ramp_rate_out_three =
    acoustic_ctrl_two[RATE_THREE_LSB +: 3];
  wire smoothing_on_out_one   = acoustic_ctrl_one[SMOOTH_ONE_BIT];
  wire smoothing_on_out_two   = acoustic_ctrl_two[SMOOTH_TWO_BIT];
  wire smoothing_on_out_three =
    acoustic_ctrl_two[SMOOTH_THREE_BIT];
  wire idle_floor_out_one   = acoustic_ctrl_one[FLOOR_ONE_BIT];
  wire idle_floor_out_two   = acoustic_ctrl_one[FLOOR_TWO_BIT];
  wire idle_floor_out_three = acoustic_ctrl_one[FLOOR_THREE_BIT];
  wire speed_sync_all       = acoustic_ctrl_one[SPEED_SYNC_BIT];

  wire [2:0] rate_sel  [3];
  wire [2:0] smooth_sel;
  wire [2:0] floor_sel;
  assign rate_sel[0] = ramp_rate_out_one;
  assign rate_sel[1] = ramp_rate_out_two;
  assign rate_sel[2] = ramp_rate_out_three;
  assign smooth_sel  = {smoothing_on_out_three, smoothing_on_out_two,
                        smoothing_on_out_one};
  assign floor_sel   = {idle_floor_out_three, idle_floor_out_two,
                        idle_floor_out_one};

  // ****************************************************************
  // slot timing, shared by all outputs
  // ****************************************************************
  logic slot_tick;

  fpwm_slot_timer #(
    .SLOT_LEN (SLOT_LEN)
  ) u_slot (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .slow_ramp (slow_ramp),
    .slot_tick (slot_tick)
  );

  // ****************************************************************
  // per output: floor register, target choice and ramp
  // ****************************************************************
  wire [7:0] target [3];
  wire [7:0] duty   [3];
  wire [2:0] wr_min;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      // floor is read-only while its output runs automatically
      assign wr_min[gi] = reg_req.wr && hit_min[gi] &&
                          !chan_in[gi].auto_mode;

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          min_duty[gi] <= RST_MIN_DUTY;
        end else if (wr_min[gi]) begin
          min_duty[gi] <= reg_req.wdata;
        end
      end

      // idle zone: off or floor; hold zone keeps the floor
      assign target[gi] =
        !chan_in[gi].auto_mode                 ? chan_in[gi].calc_duty :
        (chan_in[gi].zone == FPWM_ZONE_IDLE)   ?
          (floor_sel[gi] ? min_duty[gi] : DUTY_OFF) :
        (chan_in[gi].zone == FPWM_ZONE_HOLD)   ? min_duty[gi] :
        chan_in[gi].calc_duty;

      fpwm_ramp u_ramp (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .slot_tick (slot_tick),
        .smooth_on (smooth_sel[gi]),
        .rate_code (rate_sel[gi]),
        .target    (target[gi]),
        .duty      (duty[gi])
      );
    end
  endgenerate

  assign fan_drive_one   = duty[0];
  assign fan_drive_two   = duty[1];
  assign fan_drive_three = duty[2];

  // ****************************************************************
  // read data and tachometer sync
  // ****************************************************************
  wire [7:0] next_rdata =
    hit_one    ? acoustic_ctrl_one :
    hit_two    ? acoustic_ctrl_two :
    hit_min[0] ? min_duty[0] :
    hit_min[1] ? min_duty[1] :
    hit_min[2] ? min_duty[2] : 8'h00;

  // unmapped reads return zero; data holds until the next read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata              <= 8'h00;
      speed_sense_two_sync   <= 1'b0;
      speed_sense_three_sync <= 1'b1;
      speed_sense_four_sync  <= 1'b1;
    end else begin
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
      end
      speed_sense_two_sync   <= speed_sync_all;
      speed_sense_three_sync <= 1'b1;
      speed_sense_four_sync  <= 1'b1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_locked_write_one;
    reg_req.wr && hit_one && cfg_lock;
  endsequence

  sequence s_locked_write_two;
    reg_req.wr && hit_two && cfg_lock;
  endsequence

  lock_ctrl_one_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_locked_write_one |=> $stable(acoustic_ctrl_one))
    else $error("locked write changed first acoustic register");

  lock_ctrl_two_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_locked_write_two |=> $stable(acoustic_ctrl_two))
    else $error("locked write changed second acoustic register");

  floor_auto_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (reg_req.wr && hit_min[1] && chan_in[1].auto_mode)
    |=> $stable(min_duty[1]))
    else $error("floor register written in automatic mode");

  floor_write_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (reg_req.wr && hit_min[0] && !chan_in[0].auto_mode)
    |=> (min_duty[0] == $past(reg_req.wdata)))
    else $error("floor register did not take manual write");

  floor_reset_a: assert property (
    @(posedge ref_clk)
    $rose(rstn) |-> (min_duty[2] == RST_MIN_DUTY))
    else $error("floor register not at reset value");

  idle_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[0].auto_mode && chan_in[0].zone == FPWM_ZONE_IDLE &&
     !idle_floor_out_one) |-> (target[0] == DUTY_OFF))
    else $error("output one idle target not off");

  idle_floor_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[2].auto_mode && chan_in[2].zone == FPWM_ZONE_IDLE &&
     idle_floor_out_three) |-> (target[2] == min_duty[2]))
    else $error("output three idle target not floor");

  hold_floor_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[1].auto_mode && chan_in[1].zone == FPWM_ZONE_HOLD)
    |-> (target[1] == min_duty[1]))
    else $error("hold zone target not floor");

  smooth_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (rstn && !smoothing_on_out_one) ##1 !$past(smoothing_on_out_one)
    |-> (fan_drive_one == $past(target[0])))
    else $error("output one did not jump with smoothing off");

  ramp_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (smoothing_on_out_two && !slot_tick) |=> $stable(fan_drive_two))
    else $error("output two moved outside a slot");

  ramp_step_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (smoothing_on_out_three && slot_tick && duty[2] < target[2] &&
     (target[2] - duty[2]) > fpwm_step(ramp_rate_out_three))
    |=> (fan_drive_three ==
         8'($past(duty[2]) + fpwm_step($past(ramp_rate_out_three)))))
    else $error("output three step size wrong");

  ramp_clamp_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (smoothing_on_out_one && slot_tick && duty[0] < target[0] &&
     (target[0] - duty[0]) <= fpwm_step(ramp_rate_out_one))
    |=> (fan_drive_one == $past(target[0])))
    else $error("output one overshot or missed target");

  sync_two_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    speed_sync_all ##1 speed_sync_all |-> speed_sense_two_sync)
    else $error("sense two not synchronised with sync set");

  sync_fixed_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    speed_sense_three_sync && speed_sense_four_sync)
    else $error("sense three or four not synchronised");

  floor_one_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[0].auto_mode && chan_in[0].zone == FPWM_ZONE_IDLE &&
     idle_floor_out_one) |-> (target[0] == min_duty[0]))
    else $error("output one idle target not floor");

  floor_two_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[1].auto_mode && chan_in[1].zone == FPWM_ZONE_IDLE)
    |-> (target[1] == (idle_floor_out_two ? min_duty[1] : DUTY_OFF)))
    else $error("output two idle target wrong");

  idle_off_three_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (chan_in[2].auto_mode && chan_in[2].zone == FPWM_ZONE_IDLE &&
     !idle_floor_out_three) |-> (target[2] == DUTY_OFF))
    else $error("output three idle target not off");

  // the release edge still shows the flops in reset, so it is left out
  smooth_two_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (rstn && !smoothing_on_out_two)
    |=> (fan_drive_two == $past(target[1])))
    else $error("output two did not jump with smoothing off");

  smooth_three_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (rstn && !smoothing_on_out_three)
    |=> (fan_drive_three == $past(target[2])))
    else $error("output three did not jump with smoothing off");

  ramp_hold_three_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (smoothing_on_out_three && !slot_tick) |=> $stable(fan_drive_three))
    else $error("output three moved outside a slot");

  // falling ramps use the same step, taken off instead of added
  ramp_down_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (smoothing_on_out_one && slot_tick && duty[0] > target[0] &&
     (duty[0] - target[0]) > fpwm_step(ramp_rate_out_one))
    |=> (fan_drive_one ==
         8'($past(duty[0]) - fpwm_step($past(ramp_rate_out_one)))))
    else $error("output one down step size wrong");

  sequence s_rise_two;
    smoothing_on_out_two && slot_tick && duty[1] < target[1] &&
    (target[1] - duty[1]) > fpwm_step(ramp_rate_out_two);
  endsequence

  ramp_step_two_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_rise_two |=> (fan_drive_two ==
      8'($past(duty[1]) + fpwm_step($past(ramp_rate_out_two)))))
    else $error("output two step size wrong");

  sync_two_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !speed_sync_all ##1 !speed_sync_all |-> !speed_sense_two_sync)
    else $error("sense two synchronised with sync clear");

endmodule

// [fpwm_pkg.sv]
package fpwm_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_ACOUSTIC_CTRL_ONE  = 8'h62;
  localparam logic [7:0] ADDR_ACOUSTIC_CTRL_TWO  = 8'h63;
  localparam logic [7:0] ADDR_FAN_ONE_MIN_DUTY   = 8'h64;
  localparam logic [7:0] ADDR_FAN_TWO_MIN_DUTY   = 8'h65;
  localparam logic [7:0] ADDR_FAN_THREE_MIN_DUTY = 8'h66;

  localparam logic [7:0] RST_ACOUSTIC_CTRL = 8'h00;
  localparam logic [7:0] RST_MIN_DUTY      = 8'h80;

  // ****************************************************************
  // field positions, first acoustic control register
  // ****************************************************************
  localparam int RATE_ONE_LSB      = 0;
  localparam int SMOOTH_ONE_BIT    = 3;
  localparam int SPEED_SYNC_BIT    = 4;
  localparam int FLOOR_ONE_BIT     = 5;
  localparam int FLOOR_TWO_BIT     = 6;
  localparam int FLOOR_THREE_BIT   = 7;

  // ****************************************************************
  // field positions, second acoustic control register
  // ****************************************************************
  localparam int RATE_THREE_LSB    = 0;
  localparam int SMOOTH_THREE_BIT  = 3;
  localparam int RATE_TWO_LSB      = 4;
  localparam int SMOOTH_TWO_BIT    = 7;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 4;
  // one slot: 35 s over the 171 counts from 33% to 100% at step 1
  localparam int SLOT_TIME_US    = 204_700;
  localparam int SLOT_CYCLES     = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOW_FACTOR     = 4;
  localparam logic [7:0] DUTY_OFF = 8'h00;

  // temperature zone of the controlling channel
  typedef enum logic [1:0] {
    FPWM_ZONE_ACTIVE = 2'b00,  // above the threshold
    FPWM_ZONE_HOLD   = 2'b01,  // under threshold, above threshold - hyst
    FPWM_ZONE_IDLE   = 2'b10   // below threshold - hysteresis
  } fpwm_zone_t;

  // per output information from the fan control loop
  typedef struct packed {
    logic [7:0] calc_duty;
    logic       auto_mode;
    fpwm_zone_t zone;
  } fpwm_chan_in_t;

  // register access from the serial management port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpwm_reg_req_t;

  // duty increase per slot for each ramp code
  function automatic logic [7:0] fpwm_step(input logic [2:0] code);
    case (code)
      3'h0:    fpwm_step = 8'h01;
      3'h1:    fpwm_step = 8'h02;
      3'h2:    fpwm_step = 8'h03;
      3'h3:    fpwm_step = 8'h04;
      3'h4:    fpwm_step = 8'h08;
      3'h5:    fpwm_step = 8'h0c;
      3'h6:    fpwm_step = 8'h18;
      default: fpwm_step = 8'h30;
    endcase
  endfunction

endpackage

// [fpwm_slot_timer.sv]
`timescale 1ns/1ps
module fpwm_slot_timer #(
  parameter int SLOT_LEN = fpwm_pkg::SLOT_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // control
  input  wire logic slow_ramp,
  // slot strobe
  output logic      slot_tick
);
  import fpwm_pkg::*;

  logic [31:0] cyc_cnt;
  logic [1:0]  sub_cnt;
  wire         cyc_end = (cyc_cnt == 32'(SLOT_LEN - 1));
  wire  [1:0]  sub_last = slow_ramp ? 2'(SLOW_FACTOR - 1) : 2'h0;
  wire         sub_end = (sub_cnt >= sub_last);

  // slow mode stretches each slot four times, keeping steps the same
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_cnt   <= 32'h0;
      sub_cnt   <= 2'h0;
      slot_tick <= 1'b0;
    end else begin
      cyc_cnt   <= cyc_end ? 32'h0 : cyc_cnt + 32'h1;
      if (cyc_end) begin
        sub_cnt <= sub_end ? 2'h0 : sub_cnt + 2'h1;
      end
      slot_tick <= cyc_end && sub_end;
    end
  end

endmodule

// [fpwm_ramp.sv]
`timescale 1ns/1ps
module fpwm_ramp (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // control
  input  wire logic       slot_tick,
  input  wire logic       smooth_on,
  input  wire logic [2:0] rate_code,
  input  wire logic [7:0] target,
  // output duty
  output logic      [7:0] duty
);
  import fpwm_pkg::*;

  wire [7:0] step = fpwm_step(rate_code);
  wire [7:0] gap_up = target - duty;
  wire [7:0] gap_dn = duty - target;
  wire [7:0] next_duty;

  // clamp the last step so the target is landed on, never passed
  assign next_duty = !smooth_on        ? target :
                     !slot_tick        ? duty :
                     (duty < target)   ? ((gap_up <= step) ? target
                                                           : duty + step) :
                     (duty > target)   ? ((gap_dn <= step) ? target
                                                           : duty - step) :
                     duty;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      duty <= DUTY_OFF;
    end else begin
      duty <= next_duty;
    end
  end

endmodule

// [fpwm_fan_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// fan model: three fans turning at a speed set by their duty
// ****************************************************************
module fpwm_fan_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // duty seen by each fan
  input  wire logic [7:0] duty_one,
  input  wire logic [7:0] duty_two,
  input  wire logic [7:0] duty_three,
  // fan two shares output three when set
  input  wire logic       sense_two_sync,
  // tachometer pulses, one per fan
  output logic      [2:0] tach
);
  logic [15:0] acc_one;
  logic [15:0] acc_two;
  logic [15:0] acc_three;
  logic [7:0]  eff_two;

  // a shared fan follows output three, so its pulses track that duty
  assign eff_two = sense_two_sync ? duty_three : duty_two;
  assign tach    = {acc_three[15], acc_two[15], acc_one[15]};

  // speed grows with duty; a stopped fan gives no pulses
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_one   <= 16'h0000;
      acc_two   <= 16'h0000;
      acc_three <= 16'h0000;
    end else begin
      acc_one   <= acc_one + {8'h00, duty_one};
      acc_two   <= acc_two + {8'h00, eff_two};
      acc_three <= acc_three + {8'h00, duty_three};
    end
  end
endmodule

// [fpwm_acoustic_bench.sv]
`timescale 1ns/1ps
module fpwm_acoustic_bench;
  import fpwm_pkg::*;

  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       auto_m;
    logic [7:0] exp;
  } fpwm_row_t;

  // short slots keep the ramps quick in simulation
  localparam int SL = 8;

  logic          ref_clk;
  logic          rstn;
  logic          cfg_lock;
  logic          slow_ramp;
  fpwm_reg_req_t req;
  fpwm_chan_in_t chan [3];
  logic [7:0]    rdata;
  logic [7:0]    d1;
  logic [7:0]    d2;
  logic [7:0]    d3;
  logic          s2;
  logic          s3;
  logic          s4;
  logic [7:0]    drv [3];
  logic [7:0]    got;
  int            miscompares;
  int            n_tests;
  int            cyc;
  int            e2;
  int            steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  fpwm_row_t     rows [6] = '{
    '{8'h62, 8'h10, 1'b0, 8'h10},
    '{8'h63, 8'h5a, 1'b0, 8'h5a},
    '{8'h64, 8'h40, 1'b0, 8'h40},
    '{8'h65, 8'h20, 1'b1, 8'h80},
    '{8'h66, 8'hff, 1'b0, 8'hff},
    '{8'h70, 8'h11, 1'b0, 8'h00}};

  assign drv[0] = d1;
  assign drv[1] = d2;
  assign drv[2] = d3;

  fpwm_acoustic #(.SLOT_LEN(SL)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
    .cfg_lock(cfg_lock), .slow_ramp(slow_ramp), .chan_in(chan),
    .fan_drive_one(d1), .fan_drive_two(d2), .fan_drive_three(d3),
    .speed_sense_two_sync(s2), .speed_sense_three_sync(s3),
    .speed_sense_four_sync(s4));

  fpwm_fan_model fans (
    .ref_clk(ref_clk), .rstn(rstn), .duty_one(d1), .duty_two(d2),
    .duty_three(d3), .sense_two_sync(s2), .tach());

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // write strobe is one cycle wide, as the port expects
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // read data lands on the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_in(input logic a, input fpwm_zone_t z,
                        input logic [7:0] c);
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      chan[i] <= '{calc_duty: c, auto_mode: a, zone: z};
    end
  endtask

  // bounded wait for an output to move; n is cycles taken
  task automatic wait_move(input int i, input int lim, output int n);
    logic [7:0] prev;
    #1 prev = drv[i];
    n = 0;
    while (drv[i] === prev && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("MISMATCH t=%0t stuck got=%h exp=%h", $time, drv[i], prev);
      give_verdict();
    end
  endtask

  // ****************************************************************
  // clock and main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    rstn = 1'b0;
    cfg_lock = 1'b0;
    slow_ramp = 1'b0;
    req = '0;
    miscompares = 0;
    n_tests = 0;
    for (int i = 0; i < 3; i++) begin
      chan[i] = '{calc_duty: 8'h00, auto_mode: 1'b0, zone: FPWM_ZONE_ACTIVE};
    end
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    // write then read back each row; auto mode guards the floors
    foreach (rows[k]) begin
      set_in(rows[k].auto_m, FPWM_ZONE_ACTIVE, 8'h00);
      wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr, got);
      chk(got, rows[k].exp);
    end
    chk({7'h00, s2}, 8'h01);
    wr(8'h62, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h00, s4, s2}, 8'h02);
    chk({7'h00, s3}, 8'h01);
    // lock: acoustic registers keep their contents
    @(posedge ref_clk);
    cfg_lock <= 1'b1;
    wr(8'h62, 8'hff);
    rd(8'h62, got);
    chk(got, 8'h00);
    wr(8'h63, 8'hff);
    rd(8'h63, got);
    chk(got, 8'h5a);
    @(posedge ref_clk);
    cfg_lock <= 1'b0;
    // floors below the hysteresis point, smoothing off
    wr(8'h63, 8'h00);
    set_in(1'b1, FPWM_ZONE_IDLE, 8'h33);
    repeat (3) @(posedge ref_clk);
    #1 chk(d1 | d2 | d3, 8'h00);
    wr(8'h62, 8'ha0);
    repeat (3) @(posedge ref_clk);
    #1 chk(d1, 8'h40);
    chk(d2, 8'h00);
    chk(d3, 8'hff);
    wr(8'h62, 8'h40);
    repeat (3) @(posedge ref_clk);
    #1 chk(d2, 8'h80);
    chk(d1 | d3, 8'h00);
    wr(8'h62, 8'h00);
    set_in(1'b1, FPWM_ZONE_HOLD, 8'h33);
    repeat (3) @(posedge ref_clk);
    #1 chk(d2, 8'h80);
    set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h33);
    repeat (2) @(posedge ref_clk);
    #1 chk(d1, 8'h33);
    // every ramp code on output one, from zero toward 0x50
    for (int c = 0; c < 8; c++) begin
      wr(8'h62, 8'h00);
      set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h00);
      repeat (3) @(posedge ref_clk);
      wr(8'h62, {5'h01, 3'(c)});
      set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h50);
      wait_move(0, 4 * SL + 4, cyc);
      chk(d1, 8'(steps[c]));
      e2 = (2 * steps[c] > 8'h50) ? 8'h50 : 2 * steps[c];
      wait_move(0, 4 * SL + 4, cyc);
      chk(d1, 8'(e2));
      chk(8'(cyc), 8'(SL));
    end
    // slow ramps: slots four times longer, ramping downward
    @(posedge ref_clk);
    slow_ramp <= 1'b1;
    wr(8'h62, 8'h08);
    set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h00);
    wait_move(0, 8 * SL + 4, cyc);
    wait_move(0, 8 * SL + 4, cyc);
    chk(8'(cyc), 8'(4 * SL));
    chk(d1, 8'h4e);
    // outputs two and three from the second register
    @(posedge ref_clk);
    slow_ramp <= 1'b0;
    set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h00);
    repeat (3) @(posedge ref_clk);
    wr(8'h63, 8'hef);
    set_in(1'b0, FPWM_ZONE_ACTIVE, 8'h50);
    wait_move(2, 4 * SL + 4, cyc);
    chk(d3, 8'h30);
    chk(d2, 8'h18);
    // second reset in mid-run restores the register defaults
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rd(8'h62 + 8'(k), got);
      chk(got, (k < 2) ? 8'h00 : 8'h80);
    end
    give_verdict();
  end
endmodule
